// ===== inc/pss_pkg.sv
// shared constants and types for the supervisory sequencer
package pss_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    localparam int NUM_MFI = 5;
    localparam int CODE_W = 8;
    localparam int MODE_W = 2;

    // register indexes
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_TARGET_FREQ = 4'h1;
    localparam logic [ADDR_W-1:0] REG_ACCEL_STEP = 4'h2;
    localparam logic [ADDR_W-1:0] REG_PRELOOP_FREQ = 4'h3;
    localparam logic [ADDR_W-1:0] REG_PRELOOP_EXIT = 4'h4;
    localparam logic [ADDR_W-1:0] REG_PRELOOP_DELAY = 4'h5;
    localparam logic [ADDR_W-1:0] REG_SLEEP_DELAY = 4'h6;
    localparam logic [ADDR_W-1:0] REG_SLEEP_FREQ = 4'h7;
    localparam logic [ADDR_W-1:0] REG_WAKE_LEVEL = 4'h8;
    localparam logic [ADDR_W-1:0] REG_WAKE_MODE = 4'h9;
    localparam logic [ADDR_W-1:0] REG_MFI_BASE = 4'ha;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'hf;
    localparam int NUM_CFG = 15;

    // field positions
    localparam int CTRL_PID_EN_BIT = 0;
    localparam int STAT_FAIL_BIT = 4;
    localparam int STAT_SLEEP_BIT = 5;
    localparam int STAT_OUT_EN_BIT = 6;
    localparam int STAT_STATE_W = 3;

    // reset values
    localparam logic [DATA_W-1:0] RST_ZERO = 16'h0000;
    localparam logic [DATA_W-1:0] RST_ACCEL_STEP = 16'h0001;

    // function code of the loop-bypass input, wake modes
    localparam logic [CODE_W-1:0] FN_LOOP_BYPASS = 8'h17;
    localparam logic [MODE_W-1:0] WAKE_BELOW = 2'h0;
    localparam logic [MODE_W-1:0] WAKE_ABOVE = 2'h1;
    localparam logic [MODE_W-1:0] WAKE_BEYOND = 2'h2;

    // timing: one delay tick is one millisecond at 100 MHz
    localparam int CLK_PERIOD_PS = 10000;
    localparam int TICK_TIME_US = 1000;
    // microseconds to picoseconds, then divided by the clock period
    localparam int TICK_CYCLES_DEF = (TICK_TIME_US * 1000000) / CLK_PERIOD_PS;
    localparam int PRESC_W = 20;
    localparam int NUM_TIMERS = 2;
    localparam int TMR_SLEEP = 0;
    localparam int TMR_FAIL = 1;

    typedef enum logic [STAT_STATE_W-1:0] {
        ST_IDLE,
        ST_OPEN,
        ST_PRELOOP,
        ST_CLOSED,
        ST_SLEEP,
        ST_FAIL
    } pss_state_t;
endpackage

// ===== hdl/pss_delay_timer.sv
// prescaled delay timer that clears whenever its condition lapses
`timescale 1ns/1ps
`default_nettype none
module pss_delay_timer
    import pss_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic cond_i,
    input wire logic [DATA_W-1:0] limit_i,
    output logic expired_o
);
    localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(TICK_CYCLES - 1);

    logic [PRESC_W-1:0] presc_reg;
    logic [PRESC_W-1:0] presc_next;
    logic [DATA_W-1:0] ticks_reg;
    logic [DATA_W-1:0] ticks_next;
    logic expired_reg;
    logic expired_next;

    always_comb begin
        presc_next = presc_reg;
        ticks_next = ticks_reg;
        expired_next = expired_reg;
        if (!cond_i) begin
            // lapse before expiry restarts the whole delay
            presc_next = '0;
            ticks_next = '0;
            expired_next = 1'b0;
        end else if (ticks_reg >= limit_i) begin
            expired_next = 1'b1;
        end else if (presc_reg == PRESC_LAST) begin
            presc_next = '0;
            ticks_next = ticks_reg + 16'h0001;
        end else begin
            presc_next = presc_reg + 20'h00001;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            presc_reg <= '0;
            ticks_reg <= '0;
            expired_reg <= 1'b0;
        end else if (ce_i) begin
            presc_reg <= presc_next;
            ticks_reg <= ticks_next;
            expired_reg <= expired_next;
        end
    end

    assign expired_o = expired_reg;
endmodule
`default_nettype wire

// ===== hdl/pss_sequencer.sv
// supervisory sequencer around the process loop: pre-loop, sleep, bypass
//
// Overview of operation
// - run without loop enabled ramps normally to the target frequency
// - pre-loop phase runs open-loop at pre-loop frequency until feedback rises
// - feedback above the exit level hands over to closed-loop regulation
// - nonzero fail delay with feedback held low trips and blocks output
// - closed-loop frequency below sleep frequency for sleep delay stops output, sleeps
// - sleep keeps output stopped until the selected wake condition holds or the bypass input asserts
// - wake mode 0 resumes when feedback falls below the wake level
// - wake mode 1 resumes when feedback rises above the wake level
// - wake mode 2 resumes when reference minus feedback exceeds wake level
// - asserted input with function code 23 halts loop, runs open-loop unless tripped
// - releasing that input restarts closed-loop while run stays active
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pss_sequencer
    import pss_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    input wire logic CLK_SYS_I,
    input wire logic RESETN_I,
    input wire logic CLK_EN_I,
    input wire logic [ADDR_W-1:0] REG_ADDR_I,
    input wire logic [DATA_W-1:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [DATA_W-1:0] REG_RDATA_O,
    input wire logic RUN_CMD_I,
    input wire logic [NUM_MFI-1:0] MFI_I,
    input wire logic [DATA_W-1:0] FEEDBACK_I,
    input wire logic [DATA_W-1:0] REFERENCE_I,
    input wire logic [DATA_W-1:0] LOOP_FREQ_I,
    output logic [DATA_W-1:0] FREQ_O,
    output logic OUTPUT_EN_O,
    output logic LOOP_ACTIVE_O,
    output logic SLEEP_O,
    output logic PRELOOP_FAILURE_TRIP_O
);
    // ******************************
    // register file
    // ******************************
    logic [DATA_W-1:0] cfg_reg [NUM_CFG];
    logic [DATA_W-1:0] cfg_next [NUM_CFG];
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic [DATA_W-1:0] status_word;

    pss_state_t state_reg;
    pss_state_t state_next;
    logic [DATA_W-1:0] freq_reg;
    logic [DATA_W-1:0] freq_next;
    logic fail_reg;
    logic fail_next;

    always_comb begin
        for (int i = 0; i < NUM_CFG; i++) begin
            cfg_next[i] = cfg_reg[i];
        end
        if (REG_WR_I && REG_ADDR_I != REG_STATUS) begin
            cfg_next[REG_ADDR_I] = REG_WDATA_I;
        end
    end

    always_comb begin
        status_word = '0;
        status_word[STAT_STATE_W-1:0] = state_reg;
        status_word[STAT_FAIL_BIT] = fail_reg;
        status_word[STAT_SLEEP_BIT] = (state_reg == ST_SLEEP);
        status_word[STAT_OUT_EN_BIT] = OUTPUT_EN_O;
        rdata_next = rdata_reg;
        if (REG_RD_I) begin
            if (REG_ADDR_I == REG_STATUS) begin
                rdata_next = status_word;
            end else begin
                rdata_next = cfg_reg[REG_ADDR_I];
            end
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            for (int i = 0; i < NUM_CFG; i++) begin
                cfg_reg[i] <= RST_ZERO;
            end
            cfg_reg[REG_ACCEL_STEP] <= RST_ACCEL_STEP;
            rdata_reg <= RST_ZERO;
        end else if (CLK_EN_I) begin
            cfg_reg <= cfg_next;
            rdata_reg <= rdata_next;
        end
    end

    assign REG_RDATA_O = rdata_reg;

    // ******************************
    // configuration fields
    // ******************************
    logic pid_en;
    logic [DATA_W-1:0] target_frequency;
    logic [DATA_W-1:0] accel_step;
    logic [DATA_W-1:0] preloop_frequency;
    logic [DATA_W-1:0] preloop_exit_level;
    logic [DATA_W-1:0] preloop_fail_delay;
    logic [DATA_W-1:0] sleep_delay_time;
    logic [DATA_W-1:0] sleep_frequency;
    logic [DATA_W-1:0] wake_level;
    logic [MODE_W-1:0] wake_mode_select;

    assign pid_en = cfg_reg[REG_CTRL][CTRL_PID_EN_BIT];
    assign target_frequency = cfg_reg[REG_TARGET_FREQ];
    assign accel_step = cfg_reg[REG_ACCEL_STEP];
    assign preloop_frequency = cfg_reg[REG_PRELOOP_FREQ];
    assign preloop_exit_level = cfg_reg[REG_PRELOOP_EXIT];
    assign preloop_fail_delay = cfg_reg[REG_PRELOOP_DELAY];
    assign sleep_delay_time = cfg_reg[REG_SLEEP_DELAY];
    assign sleep_frequency = cfg_reg[REG_SLEEP_FREQ];
    assign wake_level = cfg_reg[REG_WAKE_LEVEL];
    assign wake_mode_select = cfg_reg[REG_WAKE_MODE][MODE_W-1:0];

    // ******************************
    // loop-bypass input decode
    // ******************************
    logic [NUM_MFI-1:0] bypass_hit;
    logic closed_loop_bypass;

    genvar g;
    generate
        for (g = 0; g < NUM_MFI; g++) begin : g_mfi
            // any terminal coded for bypass counts, not just the first
            assign bypass_hit[g] = MFI_I[g] &&
                (cfg_reg[REG_MFI_BASE + g][CODE_W-1:0] == FN_LOOP_BYPASS);
        end
    endgenerate

    assign closed_loop_bypass = |bypass_hit;

    // ******************************
    // delay timers
    // ******************************
    logic [NUM_TIMERS-1:0] tmr_cond;
    logic [NUM_TIMERS-1:0] tmr_expired;
    logic [DATA_W-1:0] tmr_limit [NUM_TIMERS];

    assign tmr_cond[TMR_SLEEP] = (state_reg == ST_CLOSED) &&
        (freq_reg < sleep_frequency);
    assign tmr_cond[TMR_FAIL] = (state_reg == ST_PRELOOP) &&
        (FEEDBACK_I <= preloop_exit_level) &&
        (preloop_fail_delay != RST_ZERO);
    assign tmr_limit[TMR_SLEEP] = sleep_delay_time;
    assign tmr_limit[TMR_FAIL] = preloop_fail_delay;

    generate
        for (g = 0; g < NUM_TIMERS; g++) begin : g_tmr
            pss_delay_timer #(
                .TICK_CYCLES(TICK_CYCLES)
            ) u_tmr (
                .clk_i(CLK_SYS_I),
                .resetn_i(RESETN_I),
                .ce_i(CLK_EN_I),
                .cond_i(tmr_cond[g]),
                .limit_i(tmr_limit[g]),
                .expired_o(tmr_expired[g])
            );
        end
    endgenerate

    // ******************************
    // wake condition
    // ******************************
    logic wake_hit;

    always_comb begin
        case (wake_mode_select)
            WAKE_BELOW: wake_hit = FEEDBACK_I < wake_level;
            WAKE_ABOVE: wake_hit = FEEDBACK_I > wake_level;
            // negative error never wakes in this mode
            WAKE_BEYOND: wake_hit = (REFERENCE_I > FEEDBACK_I) &&
                ((REFERENCE_I - FEEDBACK_I) > wake_level);
            default: wake_hit = 1'b0;
        endcase
    end

    // ******************************
    // frequency ramp
    // ******************************
    // one step per enabled cycle; software scales the step to the ramp time
    function automatic logic [DATA_W-1:0] ramp_to(
        input logic [DATA_W-1:0] cur,
        input logic [DATA_W-1:0] tgt,
        input logic [DATA_W-1:0] step
    );
        logic [DATA_W:0] sum;
        logic [DATA_W-1:0] res;
        sum = {1'b0, cur} + {1'b0, step};
        res = cur;
        if (cur < tgt) begin
            res = (sum >= {1'b0, tgt}) ? tgt : sum[DATA_W-1:0];
        end else if (cur > tgt) begin
            res = (cur - tgt <= step) ? tgt : cur - step;
        end
        return res;
    endfunction

    // ******************************
    // sequencer
    // ******************************
    always_comb begin
        state_next = state_reg;
        freq_next = freq_reg;
        fail_next = fail_reg;
        case (state_reg)
            ST_IDLE: begin
                freq_next = '0;
                if (RUN_CMD_I) begin
                    fail_next = 1'b0;
                    if (pid_en && !closed_loop_bypass) begin
                        state_next = ST_PRELOOP;
                    end else begin
                        state_next = ST_OPEN;
                    end
                end
            end
            ST_OPEN: begin
                freq_next = ramp_to(freq_reg, target_frequency,
                    accel_step);
                if (pid_en && !closed_loop_bypass) begin
                    state_next = ST_CLOSED;
                end
            end
            ST_PRELOOP: begin
                freq_next = ramp_to(freq_reg, preloop_frequency,
                    accel_step);
                if (closed_loop_bypass) begin
                    state_next = ST_OPEN;
                end else if (FEEDBACK_I > preloop_exit_level) begin
                    state_next = ST_CLOSED;
                end else if (tmr_expired[TMR_FAIL]) begin
                    state_next = ST_FAIL;
                    fail_next = 1'b1;
                    freq_next = '0;
                end
            end
            ST_CLOSED: begin
                freq_next = LOOP_FREQ_I;
                if (closed_loop_bypass) begin
                    state_next = ST_OPEN;
                end else if (tmr_expired[TMR_SLEEP]) begin
                    state_next = ST_SLEEP;
                    freq_next = '0;
                end
            end
            ST_SLEEP: begin
                freq_next = '0;
                if (closed_loop_bypass) begin
                    state_next = ST_OPEN;
                end else if (wake_hit) begin
                    state_next = ST_CLOSED;
                end
            end
            ST_FAIL: begin
                // trip stays latched and visible after run is dropped, until run is next asserted in idle
                freq_next = '0;
            end
            default: begin
                state_next = ST_IDLE;
                freq_next = '0;
            end
        endcase
        if (!RUN_CMD_I && state_reg != ST_IDLE) begin
            state_next = ST_IDLE;
            freq_next = '0;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            state_reg <= ST_IDLE;
            freq_reg <= '0;
            fail_reg <= 1'b0;
        end else if (CLK_EN_I) begin
            state_reg <= state_next;
            freq_reg <= freq_next;
            fail_reg <= fail_next;
        end
    end

    // ******************************
    // outputs
    // ******************************
    assign FREQ_O = freq_reg;
    assign OUTPUT_EN_O = (state_reg == ST_OPEN) ||
        (state_reg == ST_PRELOOP) || (state_reg == ST_CLOSED);
    assign LOOP_ACTIVE_O = (state_reg == ST_CLOSED);
    assign SLEEP_O = (state_reg == ST_SLEEP);
    assign PRELOOP_FAILURE_TRIP_O = fail_reg;
endmodule
`default_nettype wire

// ===== sim/pss_plant_model.sv
// sensor model: sensed level follows a set point, at once or slowly
`timescale 1ns/1ps
`default_nettype none
module pss_plant_model
    import pss_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic drive_i,
    input wire logic slow_i,
    input wire logic [DATA_W-1:0] target_i,
    output logic [DATA_W-1:0] feedback_o
);
    // ********
    // sensed level, one cycle of sensor lag
    // ********
    logic [DATA_W-1:0] level_reg;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            level_reg <= 16'h0000;
        end else if (!slow_i) begin
            level_reg <= target_i;
        end else if (drive_i && level_reg < target_i) begin
            // pressure only builds while the motor is driven
            level_reg <= level_reg + 16'h0001;
        end else if (level_reg > target_i) begin
            level_reg <= level_reg - 16'h0001;
        end
    end
    assign feedback_o = level_reg;
endmodule
`default_nettype wire

// ===== sim/pss_sequencer_props.sv
// port assertions for the sequencer, with their bind
`timescale 1ns/1ps
`default_nettype none
module pss_sequencer_props
    import pss_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    input wire logic CLK_SYS_I,
    input wire logic RESETN_I,
    input wire logic CLK_EN_I,
    input wire logic [ADDR_W-1:0] REG_ADDR_I,
    input wire logic [DATA_W-1:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic RUN_CMD_I,
    input wire logic [NUM_MFI-1:0] MFI_I,
    input wire logic [DATA_W-1:0] FEEDBACK_I,
    input wire logic [DATA_W-1:0] REFERENCE_I,
    input wire logic [DATA_W-1:0] LOOP_FREQ_I,
    input wire logic [DATA_W-1:0] FREQ_O,
    input wire logic OUTPUT_EN_O,
    input wire logic LOOP_ACTIVE_O,
    input wire logic SLEEP_O,
    input wire logic PRELOOP_FAILURE_TRIP_O
);
    // ********
    // settings shadow, so decisions can be predicted
    // ********
    logic [DATA_W-1:0] cfg_reg [NUM_CFG];
    logic byp_reg;
    logic byp, wake, run_ok;
    always_comb begin
        byp = 1'b0;
        for (int k = 0; k < NUM_MFI; k++) begin
            if (MFI_I[k] && cfg_reg[10+k][CODE_W-1:0] == FN_LOOP_BYPASS) begin
                byp = 1'b1;
            end
        end
        case (cfg_reg[9][MODE_W-1:0])
            WAKE_BELOW: wake = FEEDBACK_I < cfg_reg[8];
            WAKE_ABOVE: wake = FEEDBACK_I > cfg_reg[8];
            WAKE_BEYOND: wake = REFERENCE_I > FEEDBACK_I
                && REFERENCE_I - FEEDBACK_I > cfg_reg[8];
            default: wake = 1'b0;
        endcase
    end
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            byp_reg <= 1'b0;
            for (int i = 0; i < NUM_CFG; i++) begin
                cfg_reg[i] <= (i == 2) ? RST_ACCEL_STEP : RST_ZERO;
            end
        end else if (CLK_EN_I) begin
            byp_reg <= byp;
            if (REG_WR_I && REG_ADDR_I != REG_STATUS) begin
                cfg_reg[REG_ADDR_I] <= REG_WDATA_I;
            end
        end
    end
    // ********
    // assertions
    // ********
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESETN_I);
    // a latched trip cannot be told from idle, so it is left out
    assign run_ok = CLK_EN_I && RUN_CMD_I && !PRELOOP_FAILURE_TRIP_O;
    a_trip_blocks_out: assert property (
        PRELOOP_FAILURE_TRIP_O |-> !OUTPUT_EN_O
    ) else $error("output enabled during trip");
    a_trip_stays_set: assert property (
        CLK_EN_I && RUN_CMD_I && $past(RUN_CMD_I) && PRELOOP_FAILURE_TRIP_O
        |=> PRELOOP_FAILURE_TRIP_O
    ) else $error("trip lost while running");
    a_sleep_stopped: assert property (
        SLEEP_O |-> !OUTPUT_EN_O && !LOOP_ACTIVE_O
    ) else $error("output running in sleep");
    a_sleep_holds: assert property (
        run_ok && SLEEP_O && !byp && !wake |=> SLEEP_O
    ) else $error("left sleep without wake");
    a_wake_resumes: assert property (
        run_ok && SLEEP_O && !byp && wake |=> LOOP_ACTIVE_O
    ) else $error("wake condition ignored");
    a_bypass_opens: assert property (
        run_ok && byp && (OUTPUT_EN_O || SLEEP_O)
        |=> OUTPUT_EN_O && !LOOP_ACTIVE_O
    ) else $error("bypass did not open loop");
    a_release_closes: assert property (
        run_ok && byp_reg && !byp && cfg_reg[0][0] && OUTPUT_EN_O
        |=> LOOP_ACTIVE_O
    ) else $error("loop not restarted");
    a_exit_closes: assert property (
        run_ok && OUTPUT_EN_O && !LOOP_ACTIVE_O && !byp && cfg_reg[0][0]
        && FEEDBACK_I > cfg_reg[4] |=> LOOP_ACTIVE_O
    ) else $error("no hand-over at exit level");
    a_loop_drives: assert property (
        CLK_EN_I && LOOP_ACTIVE_O
        |=> !LOOP_ACTIVE_O || FREQ_O == $past(LOOP_FREQ_I)
    ) else $error("loop frequency not passed on");
    a_stop_clears: assert property (
        CLK_EN_I && !RUN_CMD_I |=> !OUTPUT_EN_O && FREQ_O == 16'h0000
        && !LOOP_ACTIVE_O && !SLEEP_O
    ) else $error("stop did not clear output");
endmodule
bind pss_sequencer pss_sequencer_props #(.TICK_CYCLES(TICK_CYCLES))
    pss_sequencer_props_i (.CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I),
    .CLK_EN_I(CLK_EN_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .RUN_CMD_I(RUN_CMD_I),
    .MFI_I(MFI_I), .FEEDBACK_I(FEEDBACK_I), .REFERENCE_I(REFERENCE_I),
    .LOOP_FREQ_I(LOOP_FREQ_I), .FREQ_O(FREQ_O), .OUTPUT_EN_O(OUTPUT_EN_O),
    .LOOP_ACTIVE_O(LOOP_ACTIVE_O), .SLEEP_O(SLEEP_O),
    .PRELOOP_FAILURE_TRIP_O(PRELOOP_FAILURE_TRIP_O));
`default_nettype wire

// ===== sim/pss_sequencer_tb_top.sv
// self-checking bench for the supervisory sequencer
`timescale 1ns/1ps
`default_nettype none
module pss_sequencer_tb_top import pss_pkg::*;;
    // short tick keeps the delay scenarios brief
    localparam int TICKS = 4;
    logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
    logic wr_s = 1'b0, rd_s = 1'b0, run = 1'b0, fb_slow = 1'b0;
    logic [ADDR_W-1:0] addr = 4'h0;
    logic [NUM_MFI-1:0] mfi = 5'h00;
    logic [DATA_W-1:0] wdata = 16'h0000, fb_tgt = 16'h0000;
    logic [DATA_W-1:0] ref_v = 16'h0000, loop_f = 16'h0000;
    logic [DATA_W-1:0] rdata, fb, freq, rv;
    logic out_en, loop_act, sleep, trip;
    int err_count = 0;
    int cmp_count = 0;
    int cfg_m [NUM_CFG];
    int n, k;
    always #5 clk = ~clk;
    pss_sequencer #(.TICK_CYCLES(TICKS)) pss_sequencer_i (
        .CLK_SYS_I(clk), .RESETN_I(rst_n), .CLK_EN_I(clk_en),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr_s),
        .REG_RD_I(rd_s), .REG_RDATA_O(rdata), .RUN_CMD_I(run), .MFI_I(mfi),
        .FEEDBACK_I(fb), .REFERENCE_I(ref_v), .LOOP_FREQ_I(loop_f),
        .FREQ_O(freq), .OUTPUT_EN_O(out_en), .LOOP_ACTIVE_O(loop_act),
        .SLEEP_O(sleep), .PRELOOP_FAILURE_TRIP_O(trip));
    pss_plant_model pss_plant_model_i (.clk_i(clk), .resetn_i(rst_n),
        .drive_i(out_en), .slow_i(fb_slow), .target_i(fb_tgt),
        .feedback_o(fb));
    // ********
    // shared tasks
    // ********
    task automatic chk(input logic [DATA_W-1:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic step(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task automatic wr(input int a, input int d);
        @(posedge clk);
        addr <= ADDR_W'(a);
        wdata <= DATA_W'(d);
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        if (a < NUM_CFG && clk_en) begin
            cfg_m[a] = d & 32'h0000ffff;
        end
    endtask
    task automatic rd(input int a);
        @(posedge clk);
        addr <= ADDR_W'(a);
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        rv = rdata;
    endtask
    task automatic rd_all();
        for (int i = 0; i < 16; i++) begin
            rd(i);
            chk(rv, (i < NUM_CFG) ? DATA_W'(cfg_m[i]) : RST_ZERO);
        end
    endtask
    // bounded wait on loop (0), sleep (1) or trip (2); n = cycles taken
    task automatic wait_on(input int w, input int lim);
        n = 0;
        while (!(w == 0 ? loop_act : w == 1 ? sleep : trip)) begin
            step(1);
            n++;
            if (n > lim) begin
                err_count++;
                $display("BAD %0t wait ran out", $time);
                complete_run();
            end
        end
    endtask
    initial begin
        step(20000);
        err_count++;
        $display("BAD %0t run too long", $time);
        complete_run();
    end
    // ********
    // scenarios
    // ********
    initial begin
        for (int i = 0; i < NUM_CFG; i++) begin
            cfg_m[i] = (i == 2) ? 1 : 0;
        end
        void'($urandom(32'h5b8c));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd_all();
        for (int i = 0; i < 16; i++) begin
            wr(i, (i == 0) ? 0 : $urandom);
        end
        @(posedge clk);
        clk_en <= 1'b0;
        wr(1, 16'h5a5a);
        clk_en <= 1'b1;
        rd_all();
        for (int i = 0; i < NUM_CFG; i++) begin
            wr(i, (i == 2) ? 3 : (i == 8) ? 16'h00c8 : 0);
        end
        wr(1, 20);
        @(posedge clk);
        run <= 1'b1;
        step(12);
        chk(freq, 16'h0014);
        rd(15);
        chk(rv, 16'h0041);
        @(posedge clk);
        run <= 1'b0;
        wr(0, 1);
        wr(3, 12);
        wr(4, 16'h0064);
        @(posedge clk);
        fb_tgt <= 16'h0064;
        run <= 1'b1;
        step(12);
        chk(freq, 16'h000c);
        rd(15);
        chk(rv, 16'h0042);
        @(posedge clk);
        fb_slow <= 1'b1;
        fb_tgt <= 16'h0070;
        // kept above the later sleep frequency so no early sleep starts
        loop_f <= DATA_W'($urandom_range(65535, 256));
        wait_on(0, 8);
        step(1);
        chk(freq, loop_f);
        k = $urandom_range(4, 0);
        wr(10 + k, 16'h0017);
        wr(10 + (k + 1) % 5, 16'h0016);
        @(posedge clk);
        mfi <= NUM_MFI'(1) << ((k + 1) % 5);
        step(3);
        chk(16'(loop_act), 16'h0001);
        @(posedge clk);
        mfi <= NUM_MFI'(1) << k;
        step(2);
        chk(16'({out_en, loop_act}), 16'h0002);
        @(posedge clk);
        mfi <= 5'h00;
        step(2);
        chk(16'(loop_act), 16'h0001);
        wr(7, 16'h0032);
        wr(6, 3);
        @(posedge clk);
        fb_slow <= 1'b0;
        fb_tgt <= 16'h00c8;
        ref_v <= 16'h0190;
        loop_f <= 16'h001e;
        wait_on(1, 30);
        chk(16'(n >= 3 * TICKS), 16'h0001);
        for (int m = 0; m < 4; m++) begin
            wr(9, m);
            @(posedge clk);
            if (m == 3) begin
                fb_tgt <= 16'h0000;
            end
            step(4);
            chk(16'({sleep, out_en}), 16'h0002);
            if (m < 3) begin
                @(posedge clk);
                fb_tgt <= (m == 1) ? 16'h00c9 : 16'h00c7;
                wait_on(0, 4);
                chk(16'(loop_act), 16'h0001);
                @(posedge clk);
                fb_tgt <= 16'h00c8;
                wait_on(1, 30);
            end
        end
        @(posedge clk);
        run <= 1'b0;
        wr(5, 2);
        @(posedge clk);
        run <= 1'b1;
        wait_on(2, 20);
        chk(16'(n >= 2 * TICKS && n <= 2 * TICKS + 6), 16'h0001);
        chk(16'(out_en), 16'h0000);
        @(posedge clk);
        run <= 1'b0;
        step(2);
        chk(16'(trip), 16'h0001);
        complete_run();
    end
endmodule
`default_nettype wire
